//--- src/pin_mux_pkg.sv
// Constants and carrier types for the output pin function multiplexer.
// Assumes a register access port on the device clock, offsets in 16-bit address space.
//
// Operation
// RULE1: Link pin codes 0, 1, 7 give link status
// RULE2: Link pin codes 2-5 give SOP, CRS, COL
// RULE3: Interrupt pin codes 1-7 route listed sources
// RULE4: Interrupt code 0: CRS if MII, EEE off
// RULE5: Indicator codes 1-6 sources, 7/10-15 LED function
// RULE6: Indicator code 0, MII, EEE off: COL
// RULE7: Indicator code 0, MII, EEE on: TX_ER; else LED
// RULE8: Selects reset to zero; upper bits read zero
// RULE9: New select takes effect next cycle, registered output
package pin_mux_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] link_status_pin_select_addr = 16'hff3e;
    localparam logic [15:0] interrupt_pin_select_addr   = 16'hff3f;
    localparam logic [15:0] indicator_pin_select_addr   = 16'hff41;
    localparam logic [2:0]  sel3_reset                  = 3'h0;
    localparam logic [3:0]  sel4_reset                  = 4'h0;
    localparam int          sel3_width                  = 3;
    localparam int          sel4_width                  = 4;

    // ------------------------------------------------------------
    // Select codes
    // ------------------------------------------------------------
    localparam logic [3:0] code_default  = 4'h0;
    localparam logic [3:0] code_link     = 4'h1;
    localparam logic [3:0] code_tx_sop   = 4'h2;
    localparam logic [3:0] code_rx_sop   = 4'h3;
    localparam logic [3:0] code_crs      = 4'h4;
    localparam logic [3:0] code_col      = 4'h5;
    localparam logic [3:0] code_tx_er    = 4'h6;
    localparam logic [3:0] code_native   = 4'h7;
    localparam logic [3:0] code_rsvd_lo  = 4'h8;
    localparam logic [3:0] code_rsvd_hi  = 4'h9;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic link_status;
        logic tx_sop;
        logic rx_sop;
        logic crs;
        logic col;
        logic tx_er;
        logic native_int;
        logic led;
    } pin_sources_t;

    typedef struct packed {
        logic mii_mac;
        logic eee_adv;
    } strap_cfg_t;

endpackage : pin_mux_pkg

//--- src/phy_output_pin_override_mux.sv
// Output pin function multiplexer: three select registers steer three pins.
// Assumes sources and straps are synchronous to clock; register port is single-cycle.
`timescale 1ns/1ns
module phy_output_pin_override_mux
(
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      arst_n,
    // Register access port
    input  wire logic                      reg_write,
    input  wire logic [15:0]               reg_addr,
    input  wire logic [15:0]               reg_wdata,
    output logic      [15:0]               reg_rdata,
    // Strapped configuration and pin sources
    input  wire pin_mux_pkg::strap_cfg_t   straps,
    input  wire pin_mux_pkg::pin_sources_t sources,
    // Pins
    output logic                           link_status_pin,
    output logic                           interrupt_pin,
    output logic                           indicator_pin
);

    logic [2:0] link_status_pin_select;
    logic [2:0] interrupt_pin_select;
    logic [3:0] indicator_pin_select;
    logic       next_link_pin;
    logic       next_int_pin;
    logic       next_ind_pin;
    logic       mii_eee_off;
    logic       mii_eee_on;

    // ------------------------------------------------------------
    // Select registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link_status_pin_select <= pin_mux_pkg::sel3_reset; // [RULE8]
            interrupt_pin_select   <= pin_mux_pkg::sel3_reset; // [RULE8]
            indicator_pin_select   <= pin_mux_pkg::sel4_reset; // [RULE8]
        end
        else if (reg_write)
        begin
            if (reg_addr == pin_mux_pkg::link_status_pin_select_addr)
                link_status_pin_select <= reg_wdata[pin_mux_pkg::sel3_width-1:0];
            if (reg_addr == pin_mux_pkg::interrupt_pin_select_addr)
                interrupt_pin_select <= reg_wdata[pin_mux_pkg::sel3_width-1:0];
            if (reg_addr == pin_mux_pkg::indicator_pin_select_addr)
                indicator_pin_select <= reg_wdata[pin_mux_pkg::sel4_width-1:0];
        end
    end

    // Read data is combinational; unmapped addresses return zero
    always_comb
    begin
        reg_rdata = 16'h0000;
        case (reg_addr)
            pin_mux_pkg::link_status_pin_select_addr: reg_rdata = {13'h0000, link_status_pin_select}; // [RULE8]
            pin_mux_pkg::interrupt_pin_select_addr:   reg_rdata = {13'h0000, interrupt_pin_select};   // [RULE8]
            pin_mux_pkg::indicator_pin_select_addr:   reg_rdata = {12'h000, indicator_pin_select};    // [RULE8]
            default:                                  reg_rdata = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    assign mii_eee_off = straps.mii_mac & ~straps.eee_adv;
    assign mii_eee_on  = straps.mii_mac & straps.eee_adv;

    always_comb
    begin
        // Reserved code 6 falls back to link status rather than a floating choice
        case ({1'b0, link_status_pin_select})
            pin_mux_pkg::code_tx_sop: next_link_pin = sources.tx_sop;      // [RULE2]
            pin_mux_pkg::code_rx_sop: next_link_pin = sources.rx_sop;      // [RULE2]
            pin_mux_pkg::code_crs:    next_link_pin = sources.crs;         // [RULE2]
            pin_mux_pkg::code_col:    next_link_pin = sources.col;         // [RULE2]
            default:                  next_link_pin = sources.link_status; // [RULE1]
        endcase
    end

    always_comb
    begin
        case ({1'b0, interrupt_pin_select})
            pin_mux_pkg::code_default:
                next_int_pin = mii_eee_off ? sources.crs : sources.native_int; // [RULE4]
            pin_mux_pkg::code_link:   next_int_pin = sources.link_status; // [RULE3]
            pin_mux_pkg::code_tx_sop: next_int_pin = sources.tx_sop;      // [RULE3]
            pin_mux_pkg::code_rx_sop: next_int_pin = sources.rx_sop;      // [RULE3]
            pin_mux_pkg::code_crs:    next_int_pin = sources.crs;         // [RULE3]
            pin_mux_pkg::code_col:    next_int_pin = sources.col;         // [RULE3]
            pin_mux_pkg::code_tx_er:  next_int_pin = sources.tx_er;       // [RULE3]
            default:                  next_int_pin = sources.native_int;  // [RULE3]
        endcase
    end

    always_comb
    begin
        // Reserved codes 8 and 9 fall back to the LED function
        case (indicator_pin_select)
            pin_mux_pkg::code_default:
            begin
                if (mii_eee_off)
                    next_ind_pin = sources.col;   // [RULE6]
                else if (mii_eee_on)
                    next_ind_pin = sources.tx_er; // [RULE7]
                else
                    next_ind_pin = sources.led;   // [RULE7]
            end
            pin_mux_pkg::code_link:    next_ind_pin = sources.link_status; // [RULE5]
            pin_mux_pkg::code_tx_sop:  next_ind_pin = sources.tx_sop;      // [RULE5]
            pin_mux_pkg::code_rx_sop:  next_ind_pin = sources.rx_sop;      // [RULE5]
            pin_mux_pkg::code_crs:     next_ind_pin = sources.crs;         // [RULE5]
            pin_mux_pkg::code_col:     next_ind_pin = sources.col;         // [RULE5]
            pin_mux_pkg::code_tx_er:   next_ind_pin = sources.tx_er;       // [RULE5]
            pin_mux_pkg::code_rsvd_lo: next_ind_pin = sources.led;
            pin_mux_pkg::code_rsvd_hi: next_ind_pin = sources.led;
            default:                   next_ind_pin = sources.led;         // [RULE5]
        endcase
    end

    // ------------------------------------------------------------
    // Registered pin drivers
    // ------------------------------------------------------------
    // Registering avoids glitches when the select changes mid-cycle
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link_status_pin <= 1'b0;
            interrupt_pin   <= 1'b0;
            indicator_pin   <= 1'b0;
        end
        else
        begin
            link_status_pin <= next_link_pin; // [RULE9]
            interrupt_pin   <= next_int_pin;  // [RULE9]
            indicator_pin   <= next_ind_pin;  // [RULE9]
        end
    end

endmodule : phy_output_pin_override_mux

//--- bench/pin_mux_asserts.sv
// Checker for the output pin multiplexer.
// Sees only the top module's ports; attached by bind.
`timescale 1ns/1ns
module pin_mux_asserts
(
    // Clock, reset, register port
    input wire logic                      clock,
    input wire logic                      arst_n,
    input wire logic                      reg_write,
    input wire logic [15:0]               reg_addr,
    input wire logic [15:0]               reg_wdata,
    input wire logic [15:0]               reg_rdata,
    // Straps, sources and pins
    input wire pin_mux_pkg::strap_cfg_t   straps,
    input wire pin_mux_pkg::pin_sources_t sources,
    input wire logic                      link_status_pin,
    input wire logic                      interrupt_pin,
    input wire logic                      indicator_pin
);
    // ------------
    // Properties
    // ------------
    localparam logic [15:0] la = pin_mux_pkg::link_status_pin_select_addr;
    localparam logic [15:0] ia = pin_mux_pkg::interrupt_pin_select_addr;
    localparam logic [15:0] da = pin_mux_pkg::indicator_pin_select_addr;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Pin shows the new source two edges after the write is taken
    sequence sel_wr(logic [15:0] a, logic [3:0] c);
        reg_write && reg_addr == a && reg_wdata[3:0] == c;
    endsequence
    link_code_a: assert property (sel_wr(la, 4'h7) |-> ##2 link_status_pin == $past(sources.link_status))
        else $error("link pin wrong");
    link_sop_a: assert property (sel_wr(la, 4'h2) |-> ##2 link_status_pin == $past(sources.tx_sop))
        else $error("link pin wrong");
    int_txer_a: assert property (sel_wr(ia, 4'h6) |-> ##2 interrupt_pin == $past(sources.tx_er))
        else $error("int pin wrong");
    int_default_a: assert property (sel_wr(ia, 4'h0) ##1 straps == 2'b10 |=> interrupt_pin == $past(sources.crs))
        else $error("int pin wrong");
    ind_route_a: assert property (sel_wr(da, 4'h5) |-> ##2 indicator_pin == $past(sources.col))
        else $error("indicator wrong");
    ind_col_a: assert property (sel_wr(da, 4'h0) ##1 straps == 2'b10 |=> indicator_pin == $past(sources.col))
        else $error("indicator wrong");
    ind_txer_a: assert property (sel_wr(da, 4'h0) ##1 straps == 2'b11 |=> indicator_pin == $past(sources.tx_er))
        else $error("indicator wrong");
    upper_zero_a: assert property (reg_rdata[15:4] == 12'h000)
        else $error("upper bits set");
    read_back_a: assert property (sel_wr(ia, 4'h3) ##1 reg_addr == ia |-> reg_rdata == 16'h0003)
        else $error("select not updated");
endmodule : pin_mux_asserts

bind phy_output_pin_override_mux pin_mux_asserts i_chk (.clock, .arst_n, .reg_write, .reg_addr, .reg_wdata,
    .reg_rdata, .straps, .sources, .link_status_pin, .interrupt_pin, .indicator_pin);

//--- bench/phy_output_pin_override_mux_test.sv
// Self-checking bench for the output pin multiplexer.
// Drives every port itself; the checker is bound in separately.
`timescale 1ns/1ns
module phy_output_pin_override_mux_test;
    // ------------
    // Bench
    // ------------
    localparam logic [15:0] addr [3] = '{pin_mux_pkg::link_status_pin_select_addr,
        pin_mux_pkg::interrupt_pin_select_addr, pin_mux_pkg::indicator_pin_select_addr};
    logic                      clock = 1'b0;
    logic                      arst_n = 1'b0;
    logic                      reg_write = 1'b0;
    logic [15:0]               reg_addr = 16'h0000;
    logic [15:0]               reg_wdata = 16'h0000;
    logic [15:0]               reg_rdata;
    pin_mux_pkg::strap_cfg_t   straps = '0;
    pin_mux_pkg::pin_sources_t sources = '0;
    logic [2:0]                pins;
    int                        bad_count = 0;
    int                        num_checks = 0;
    always #2 clock = ~clock;
    phy_output_pin_override_mux i_dut (.clock, .arst_n, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .straps,
        .sources, .link_status_pin(pins[0]), .interrupt_pin(pins[1]), .indicator_pin(pins[2]));
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    // Bit of pin_sources_t expected on pin p for code c and straps s
    function automatic int src_bit(int p, logic [3:0] c, logic [1:0] s);
        if (c >= 4'h1 && c <= 4'h5) return 8 - c;
        if (c == 4'h0 && p == 1) return (s == 2'b10) ? 4 : 1;
        if (c == 4'h0 && p == 2) return s[1] ? (s[0] ? 2 : 3) : 0;
        if (p == 0) return 7;
        if (p == 1) return 8 - c;
        return (c == 4'h6) ? 2 : 0;
    endfunction : src_bit
    task automatic reset_values();
        @(posedge clock);
        sources <= '1;
        repeat (2) @(posedge clock);
        #1 chk(16'h0007, {13'h0, pins});
        for (int p = 0; p < 3; p++)
        begin
            @(posedge clock);
            reg_addr <= addr[p];
            @(posedge clock);
            #1 chk(16'h0000, reg_rdata);
        end
    endtask : reset_values
    task automatic route_all();
        logic [7:0] one;
        for (int p = 0; p < 3; p++)
            for (int s = 0; s < 4; s++)
                for (int c = 0; c < (p == 2 ? 16 : 8); c++)
                begin
                    one = 8'h01 << src_bit(p, c[3:0], s[1:0]);
                    @(posedge clock);
                    {reg_write, reg_addr, reg_wdata, straps, sources} <= {1'b1, addr[p], 12'hfff, c[3:0], s[1:0], one};
                    @(posedge clock);
                    reg_write <= 1'b0;
                    @(posedge clock);
                    #1 chk(16'h0001, {15'h0, pins[p]});
                    chk({12'h0, c[3:0]}, reg_rdata);
                    @(posedge clock);
                    sources <= ~one;
                    @(posedge clock);
                    #1 chk(16'h0000, {15'h0, pins[p]});
                end
    endtask : route_all
    task automatic odd_cases();
        @(posedge clock);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, 16'hff40, 16'hffff};
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
        #1 chk(16'h0000, reg_rdata);
        @(posedge clock);
        reg_addr <= addr[2];
        @(posedge clock);
        #1 chk(16'h000f, reg_rdata);
        @(posedge clock);
        arst_n <= 1'b0;
        @(posedge clock);
        #1 chk(16'h0000, reg_rdata);
        @(posedge clock);
        arst_n <= 1'b1;
    endtask : odd_cases
    task automatic end_of_test();
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        reset_values();
        route_all();
        odd_cases();
        end_of_test();
    end
    // Run needs about 700 cycles; cut off well beyond that
    initial
    begin
        #20000;
        bad_count++;
        end_of_test();
    end
endmodule : phy_output_pin_override_mux_test
